/* File: rtl/exc_sequencer.sv */
/*
  Exception sequencer of the CPU: reset entry, interrupt and trap
  acceptance, stacking of pc and flags, mask update and vector fetch,
  plus its APB control registers.
  Assumes the core pauses while core_hold is high, pulses instr_done at
  each instruction end and answers memory requests with mem_rsp.ack.
*/
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module exc_sequencer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources
  input wire logic nmi_pin,
  input wire logic [5:0] ext_int_0_to_5,
  input wire logic [exc_pkg::N_INT-1:0] int_req,
  input wire logic watchdog_ovf,
  // core side
  input wire logic advanced_mode,
  input wire logic instr_done,
  input wire logic trap_exec,
  input wire logic [1:0] trap_sel,
  input wire logic [23:0] prog_counter,
  input wire logic [7:0] cond_flags,
  input wire logic [31:0] stack_ptr,
  output logic core_hold,
  output logic module_clear,
  output logic pc_load,
  output logic [23:0] pc_new,
  output logic flags_load,
  output logic [7:0] flags_new,
  output logic sp_load,
  output logic [31:0] sp_new,
  output logic int_ack,
  output logic [5:0] ack_vector,
  // memory bus
  output exc_pkg::mem_req_s mem_req,
  input wire exc_pkg::mem_rsp_s mem_rsp
);
  import exc_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 7'h00;
      pin_s2 <= 7'h00;
    end else begin
      pin_s1 <= {nmi_pin, ext_int_0_to_5};
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic [7:0] system_ctl;
  logic [7:0] prio_sel_a;
  logic [7:0] prio_sel_b;
  seq_state_e state;
  logic [5:0] cur_vec;
  logic trap_pend;

  wire hit_ctl = paddr == OFS_SYSTEM_CTL;
  wire hit_pa = paddr == OFS_PRIO_SEL_A;
  wire hit_pb = paddr == OFS_PRIO_SEL_B;
  wire hit_st = paddr == OFS_STATUS;
  wire addr_ok = hit_ctl | hit_pa | hit_pb | hit_st;
  wire wr_en = psel & penable & pwrite & addr_ok;
  wire setup = psel & ~penable;
  wire user_flag_select = system_ctl[UE_BIT];
  wire [31:0] status_word = {21'h00_0000, trap_pend,
                             state == ST_LOCKOUT, state, cur_vec};
  wire [31:0] rd_mux = hit_ctl ? {24'h00_0000, system_ctl} :
                       hit_pa ? {24'h00_0000, prio_sel_a} :
                       hit_pb ? {24'h00_0000, prio_sel_b} :
                       hit_st ? status_word : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // reset value of system_ctl makes the second flag a user bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_ctl <= SYSTEM_CTL_RESET;
      prio_sel_a <= PRIO_SEL_RESET;
      prio_sel_b <= PRIO_SEL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      // watchdog overflow clears the registers like the reset pin
      if (watchdog_ovf) begin
        system_ctl <= SYSTEM_CTL_RESET;
        prio_sel_a <= PRIO_SEL_RESET;
        prio_sel_b <= PRIO_SEL_RESET;
      end else begin
        if (wr_en && hit_ctl) system_ctl <= pwdata[7:0];
        if (wr_en && hit_pa) prio_sel_a <= pwdata[7:0];
        if (wr_en && hit_pb) prio_sel_b <= pwdata[7:0];
      end
      if (setup) prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // interrupt selection and masking
  // ----------------------------------------------------------------
  wire mask_i = cond_flags[I_BIT];
  wire mask_ui = cond_flags[UI_BIT];
  // three-level masking only when the second flag acts as a mask
  wire block_all = mask_i & (user_flag_select | mask_ui);
  wire lvl1_only = mask_i & ~user_flag_select & ~mask_ui;
  logic arb_valid;
  logic [5:0] arb_vector;

  int_arbiter u_arb (
    .nmi(pin_s2[6]),
    .irq(pin_s2[5:0]),
    .intr(int_req),
    .prio({prio_sel_a, prio_sel_b}),
    .lvl1_only(lvl1_only),
    .block_all(block_all),
    .valid(arb_valid),
    .vector(arb_vector)
  );

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  logic kind_trap;
  logic [31:0] sp_work;
  logic [23:0] pc_save;
  logic [7:0] ccr_save;
  logic [1:0] pend_sel;
  seq_state_e next_state;
  logic [5:0] next_vec;
  logic next_kind_trap;
  logic next_trap_pend;
  logic [1:0] next_pend_sel;
  mem_req_s next_mem_req;
  logic next_pc_load;
  logic next_flags_load;
  logic [7:0] next_flags_new;
  logic next_sp_load;
  logic next_int_ack;

  // ----------------------------------------------------------------
  // acceptance decisions
  // ----------------------------------------------------------------
  wire in_run = state == ST_RUN;
  wire in_lock = state == ST_LOCKOUT;
  wire go = instr_done | trap_pend;
  // the lockout state never takes an interrupt, only a trap
  wire start_int = in_run & go & arb_valid;
  wire trap_now = instr_done & trap_exec & (in_run | in_lock);
  wire start_trap = ~start_int & (trap_now | (in_run & trap_pend));
  wire [1:0] sel_now = trap_now ? trap_sel : pend_sel;
  wire [5:0] trap_vec = VEC_TRAP_BASE + {4'h0, sel_now};
  wire [31:0] sp_even = {stack_ptr[31:1], 1'b0};
  wire [31:0] sp_m2 = sp_work - 32'h0000_0002;
  wire [31:0] sp_m4 = sp_work - 32'h0000_0004;
  wire [23:0] vec_addr = advanced_mode ? {16'h0000, cur_vec, 2'b00} :
                         {17'h0_0000, cur_vec, 1'b0};
  wire [23:0] vec_target = advanced_mode ? mem_rsp.rdata[23:0] :
                           {8'h00, mem_rsp.rdata[15:0]};
  // second flag joins the mask only while it acts as a mask
  wire [7:0] masked_ccr = ccr_save | (8'h01 << I_BIT) |
    (user_flag_select ? 8'h00 : (8'h01 << UI_BIT));
  wire issue = ~mem_req.req;
  wire done = mem_req.req & mem_rsp.ack;

  assign core_hold = ~(in_run | in_lock);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_vec = cur_vec;
    next_kind_trap = kind_trap;
    next_trap_pend = trap_pend;
    next_pend_sel = pend_sel;
    next_mem_req = mem_req;
    next_pc_load = 1'b0;
    next_flags_load = 1'b0;
    next_flags_new = flags_new;
    next_sp_load = 1'b0;
    next_int_ack = 1'b0;
    case (state)
      ST_RST_VEC, ST_VEC: begin
        // vector read completes before the handler's first fetch
        if (issue) begin
          next_mem_req = '{req: 1'b1, we: 1'b0, lng: advanced_mode,
                           addr: vec_addr, wdata: 32'h0000_0000};
        end else if (done) begin
          next_mem_req = MREQ_IDLE;
          next_pc_load = 1'b1;
          if (state == ST_RST_VEC) begin
            next_state = ST_LOCKOUT;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_LOCKOUT, ST_RUN: begin
        if (start_int || start_trap) begin
          next_state = ST_PUSH_HI;
          next_kind_trap = start_trap;
          next_vec = start_int ? arb_vector : trap_vec;
        end else if (in_lock && instr_done) begin
          next_state = ST_RUN;
        end
        if (start_int && trap_now) begin
          next_trap_pend = 1'b1;
          next_pend_sel = trap_sel;
        end else if (start_trap) begin
          next_trap_pend = 1'b0;
        end
      end
      ST_PUSH_HI: begin
        if (issue && advanced_mode) begin
          next_mem_req = '{req: 1'b1, we: 1'b1, lng: 1'b1,
                           addr: sp_m4[23:0],
                           wdata: {ccr_save, pc_save}};
        end else if (issue) begin
          next_mem_req = '{req: 1'b1, we: 1'b1, lng: 1'b0,
                           addr: sp_m2[23:0],
                           wdata: {16'h0000, pc_save[15:0]}};
        end else if (done) begin
          next_mem_req = MREQ_IDLE;
          if (advanced_mode) begin
            next_state = ST_MASK;
          end else begin
            next_state = ST_PUSH_LO;
          end
        end
      end
      ST_PUSH_LO: begin
        if (issue) begin
          next_mem_req = '{req: 1'b1, we: 1'b1, lng: 1'b0,
                           addr: sp_m4[23:0],
                           wdata: {16'h0000, ccr_save, ccr_save}};
        end else if (done) begin
          next_mem_req = MREQ_IDLE;
          next_state = ST_MASK;
        end
      end
      ST_MASK: begin
        next_sp_load = 1'b1;
        next_flags_load = 1'b1;
        next_flags_new = masked_ccr;
        next_int_ack = ~kind_trap;
        next_state = ST_VEC;
      end
      default: begin
        next_state = ST_RST_VEC;
        next_mem_req = MREQ_IDLE;
      end
    endcase
    // watchdog overflow restarts the whole reset sequence
    if (watchdog_ovf) begin
      next_state = ST_RST_VEC;
      next_vec = VEC_RESET;
      next_mem_req = MREQ_IDLE;
      next_trap_pend = 1'b0;
      next_flags_load = 1'b1;
      next_flags_new = FLAGS_RESET;
    end
  end

  // ----------------------------------------------------------------
  // sequencer flip-flops
  // ----------------------------------------------------------------
  // reset state holds the reset vector fetch ready to go at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RST_VEC;
      cur_vec <= VEC_RESET;
      kind_trap <= 1'b0;
      trap_pend <= 1'b0;
      pend_sel <= 2'b00;
      mem_req <= MREQ_IDLE;
      flags_load <= 1'b1;
      flags_new <= FLAGS_RESET;
      module_clear <= 1'b1;
    end else begin
      state <= next_state;
      cur_vec <= next_vec;
      kind_trap <= next_kind_trap;
      trap_pend <= next_trap_pend;
      pend_sel <= next_pend_sel;
      mem_req <= next_mem_req;
      flags_load <= next_flags_load;
      flags_new <= next_flags_new;
      module_clear <= watchdog_ovf;
    end
  end

  // captured context and core load strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_work <= 32'h0000_0000;
      pc_save <= 24'h00_0000;
      ccr_save <= 8'h00;
      pc_load <= 1'b0;
      pc_new <= 24'h00_0000;
      sp_load <= 1'b0;
      sp_new <= 32'h0000_0000;
      int_ack <= 1'b0;
      ack_vector <= 6'h00;
    end else begin
      if (start_int || start_trap) begin
        sp_work <= sp_even;
        pc_save <= prog_counter;
        ccr_save <= cond_flags;
      end
      pc_load <= next_pc_load & ~watchdog_ovf;
      if (next_pc_load) pc_new <= vec_target;
      sp_load <= next_sp_load & ~watchdog_ovf;
      if (next_sp_load) sp_new <= sp_m4;
      int_ack <= next_int_ack & ~watchdog_ovf;
      if (next_int_ack) ack_vector <= cur_vec;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_trap_only;
    in_run && instr_done && trap_exec && !arb_valid && !watchdog_ovf;
  endsequence

  sequence s_push_entry;
    state == ST_PUSH_HI ##1 state == ST_PUSH_HI && mem_req.req;
  endsequence

  a_reset_vec_zero: assert property (
    state == ST_RST_VEC && mem_req.req |-> mem_req.addr == 24'h00_0000
      && mem_req.lng == advanced_mode && !mem_req.we)
    else $error("reset vector not fetched from zero");

  a_trap_unmasked: assert property (
    s_trap_only |=> state == ST_PUSH_HI
      && cur_vec == VEC_TRAP_BASE + {4'h0, $past(trap_sel)})
    else $error("trap not taken or wrong trap vector");

  a_int_over_trap: assert property (
    in_run && instr_done && trap_exec && arb_valid && !watchdog_ovf
      |=> trap_pend && !kind_trap && state == ST_PUSH_HI)
    else $error("trap not deferred behind interrupt");

  a_push_even_write: assert property (
    s_push_entry |-> mem_req.we && !mem_req.addr[0]
      && mem_req.addr == (advanced_mode ? sp_m4[23:0] : sp_m2[23:0]))
    else $error("stack push address wrong or odd");

  a_mask_then_vec: assert property (
    state == ST_MASK && !watchdog_ovf |=> state == ST_VEC && flags_load
      && flags_new[I_BIT] && sp_load && sp_new == sp_m4)
    else $error("mask step out of order");

  a_trap_second_mask: assert property (
    state == ST_MASK && kind_trap && !user_flag_select
      && !watchdog_ovf |=> flags_new[UI_BIT] && flags_new[I_BIT])
    else $error("second mask not set on trap");

  a_lockout_no_int: assert property (
    in_lock ##1 state == ST_PUSH_HI |-> kind_trap)
    else $error("interrupt taken before first instruction");

  a_wdt_reset: assert property (
    watchdog_ovf |=> state == ST_RST_VEC && module_clear
      && flags_new == FLAGS_RESET && !mem_req.req && !pc_load)
    else $error("watchdog overflow did not reset sequencer");

  a_vec_fetch_width: assert property (
    state == ST_VEC && mem_req.req |-> !mem_req.we
      && mem_req.lng == advanced_mode && mem_req.addr == vec_addr)
    else $error("vector fetch width or address wrong");

  a_ack_after_int: assert property (
    $rose(int_ack) |-> $past(state) == ST_MASK && !kind_trap
      && ack_vector == cur_vec)
    else $error("interrupt acknowledged out of sequence");

endmodule
`default_nettype wire

/* File: common/exc_pkg.sv */
/*
  Shared constants and types of the CPU exception sequencer: vector
  numbers, register offsets and reset values, sequencer states and the
  memory request and answer carriers.
  Assumes one 200 MHz clock domain and a 32-bit APB register port.
*/
package exc_pkg;

  // ----------------------------------------------------------------
  // vector numbers and source counts
  // ----------------------------------------------------------------
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0] VEC_IRQ_BASE = 6'h0C;
  localparam logic [5:0] VEC_INT_BASE = 6'h14;
  localparam int N_EXT = 6;
  localparam int N_INT = 36;
  localparam int PRIO_GRP = 3;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYSTEM_CTL = 8'h00;
  localparam logic [7:0] OFS_PRIO_SEL_A = 8'h04;
  localparam logic [7:0] OFS_PRIO_SEL_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] SYSTEM_CTL_RESET = 8'h09;
  localparam logic [7:0] PRIO_SEL_RESET = 8'h00;
  localparam int UE_BIT = 3;
  localparam int I_BIT = 7;
  localparam int UI_BIT = 6;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  // ----------------------------------------------------------------
  // sequencer states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RST_VEC = 3'b000,
    ST_LOCKOUT = 3'b001,
    ST_RUN = 3'b010,
    ST_PUSH_HI = 3'b011,
    ST_PUSH_LO = 3'b100,
    ST_MASK = 3'b101,
    ST_VEC = 3'b110
  } seq_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic lng;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mem_rsp_s;

  localparam mem_req_s MREQ_IDLE = '{
    req: 1'b0, we: 1'b0, lng: 1'b0, addr: 24'h00_0000,
    wdata: 32'h0000_0000};

endpackage

/* File: rtl/int_arbiter.sv */
/*
  Interrupt arbiter: maps every request onto its vector number and
  picks the winner by level and then by lowest vector number.
  Assumes requests are levels held until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module int_arbiter (
  // requests
  input wire logic nmi,
  input wire logic [5:0] irq,
  input wire logic [exc_pkg::N_INT-1:0] intr,
  // priority and masking
  input wire logic [15:0] prio,
  input wire logic lvl1_only,
  input wire logic block_all,
  // winner
  output logic valid,
  output logic [5:0] vector
);
  import exc_pkg::*;

  logic [63:0] req;
  logic [63:0] hi;
  logic [63:0] elig_hi;
  logic [63:0] elig_lo;
  logic [63:0] nmi_pass;

  function automatic logic [5:0] lowest(input logic [63:0] m);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (m[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // one slot per vector number
  // ----------------------------------------------------------------
  for (genvar v = 0; v < 64; v++) begin : g_vec
    if (6'(v) == VEC_NMI) begin : g_nmi
      assign req[v] = nmi;
      assign hi[v] = 1'b1;
      assign nmi_pass[v] = 1'b1;
    end else if (v >= int'(VEC_IRQ_BASE) &&
                 v < int'(VEC_IRQ_BASE) + N_EXT) begin : g_irq
      localparam int K = v - int'(VEC_IRQ_BASE);
      localparam int B = (K < 2) ? 15 - K : ((K < 4) ? 13 : 12);
      assign req[v] = irq[K];
      assign hi[v] = prio[B];
      assign nmi_pass[v] = 1'b0;
    end else if (v >= int'(VEC_INT_BASE) &&
                 v < int'(VEC_INT_BASE) + N_INT) begin : g_int
      localparam int K = v - int'(VEC_INT_BASE);
      assign req[v] = intr[K];
      assign hi[v] = prio[11 - K / PRIO_GRP];
      assign nmi_pass[v] = 1'b0;
    end else begin : g_rsvd
      assign req[v] = 1'b0;
      assign hi[v] = 1'b0;
      assign nmi_pass[v] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // level, then lowest vector number
  // ----------------------------------------------------------------
  assign elig_hi = req & hi & ({64{~block_all}} | nmi_pass);
  assign elig_lo = req & ~hi & {64{~block_all & ~lvl1_only}};
  assign valid = (|elig_hi) | (|elig_lo);
  assign vector = (|elig_hi) ? lowest(elig_hi) : lowest(elig_lo);

endmodule
`default_nettype wire

/* File: bench/mem_model.sv */
/*
  Memory partner of the exception sequencer: acks each request one or
  four cycles after it rises and returns 0x4000 or'ed with the address.
  Assumes each request holds its fields until its ack.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // clock, reset and pace
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // memory bus
  input wire exc_pkg::mem_req_s mem_req,
  output exc_pkg::mem_rsp_s mem_rsp
);
  import exc_pkg::*;
  logic [2:0] cnt;
  logic [31:0] pat;
  logic answer;
  // ----------------------------------------------------------------
  // answer pacing
  // ----------------------------------------------------------------
  assign pat = {16'h0000, 16'h4000 | mem_req.addr[15:0]};
  assign answer = mem_req.req && cnt == (slow ? 3'h4 : 3'h1);
  // data is only valid with ack
  assign mem_rsp = '{ack: answer, rdata: answer ? pat : ~pat};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 3'h0;
    else if (!mem_req.req || answer) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
  Self-checking bench of the exception sequencer.
  Assumes mem_model answers the memory bus of the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) chk(32'(a), 32'(b))
module tb_top;
  import exc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, fl = 8'h80, fln, lf;
  logic [31:0] pwdata = 32'h0000_0000, prdata, sp = 32'h0000_1001, spn;
  logic [31:0] r, ls;
  logic pready, pslverr, nmi = 0, wd = 0, adv = 1, idone = 0, trap = 0;
  logic [5:0] ext = 6'h00, avec, av;
  logic [N_INT-1:0] int_req = '0;
  logic [1:0] tsel = 2'h0;
  logic [23:0] pc = 24'h12_3456, pcn;
  logic hold, mclr, pcl, fll, spl, iack, slow = 0, e;
  mem_req_s mreq;
  mem_rsp_s mrsp;
  mem_req_s q[$];
  int miscompares = 0, checks_done = 0, n_ack = 0;
  // ----------------------------------------------------------------
  // design, partner and monitor
  // ----------------------------------------------------------------
  exc_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi),
    .ext_int_0_to_5(ext), .int_req(int_req), .watchdog_ovf(wd),
    .advanced_mode(adv), .instr_done(idone), .trap_exec(trap),
    .trap_sel(tsel), .prog_counter(pc), .cond_flags(fl), .stack_ptr(sp),
    .core_hold(hold), .module_clear(mclr), .pc_load(pcl), .pc_new(pcn),
    .flags_load(fll), .flags_new(fln), .sp_load(spl), .sp_new(spn),
    .int_ack(iack), .ack_vector(avec), .mem_req(mreq), .mem_rsp(mrsp));
  mem_model i_mem (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mem_req(mreq), .mem_rsp(mrsp));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mreq.req === 1'b1 && mrsp.ack === 1'b1) q.push_back(mreq);
    if (iack === 1'b1) begin
      n_ack++;
      av = avec;
    end
    if (fll === 1'b1) lf = fln;
    if (spl === 1'b1) ls = spn;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    checks_done++;
    if (a !== b) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, a, b);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic step(input logic t, input logic [1:0] s);
    @(posedge pclk);
    idone <= 1;
    trap <= t;
    tsel <= s;
    @(posedge pclk);
    idone <= 0;
    trap <= 0;
  endtask
  task automatic exc(input logic [23:0] va, input int n);
    int i;
    for (i = 0; i < 80; i++) begin
      @(posedge pclk);
      #1;
      if (pcl === 1'b1) break;
    end
    if (i == 80) begin
      miscompares++;
      end_of_test();
    end
    `CHK(q.size(), n + 1);
    `CHK(q[n].addr, va);
    `CHK({q[n].we, q[n].lng}, {1'b0, adv});
    `CHK(pcn, 24'h00_4000 | va);
  endtask
  task automatic rst(input int n);
    @(posedge pclk);
    presetn <= 0;
    repeat (n - 1) @(posedge pclk);
    #1;
    `CHK(fln, FLAGS_RESET);
    `CHK({mclr, hold, fll}, 3'h7);
    q.delete();
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    #1;
    `CHK(mreq.req, 1);
    exc(24'h00_0000, 0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_nmi;
    @(posedge pclk);
    nmi <= 1;
    repeat (10) @(posedge pclk);
    step(0, 2'h0);
    #1;
    `CHK(n_ack, 0);
    `CHK(hold, 0);
    q.delete();
    step(0, 2'h0);
    exc(24'h00_001C, 1);
    `CHK(av, VEC_NMI);
    `CHK(q[0].addr, 24'h00_0FFC);
    `CHK(ls, 32'h0000_0FFC);
    `CHK(q[0].wdata, {fl, pc});
    `CHK(lf[I_BIT], 1);
    @(posedge pclk);
    nmi <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_trap(input logic ui);
    int s;
    for (s = 0; s < 4; s++) begin
      q.delete();
      step(1, s[1:0]);
      exc(24'(32 + 4 * s), 1);
      `CHK(lf, {1'b1, ui, fl[5:0]});
    end
  endtask
  task automatic t_normal;
    int k;
    @(posedge pclk);
    adv <= 0;
    slow <= 1;
    rst(12);
    step(0, 2'h0);
    @(posedge pclk);
    fl <= 8'h00;
    ext <= 6'h01;
    k = n_ack;
    repeat (6) @(posedge pclk);
    #1;
    `CHK(n_ack, k);
    `CHK(hold, 0);
    q.delete();
    step(1, 2'h2);
    // core takes the masked flags, so irq0 stays off for the trap
    @(posedge pclk);
    fl <= 8'h80;
    exc(24'h00_0018, 2);
    `CHK(av, VEC_IRQ_BASE);
    `CHK(q[0].addr, 24'h00_0FFE);
    `CHK(q[1].addr, 24'h00_0FFC);
    `CHK(q[0].wdata[15:0], pc[15:0]);
    q.delete();
    exc(24'h00_0014, 2);
    @(posedge pclk);
    ext <= 6'h00;
    fl <= 8'h00;
    int_req[5] <= 1'b1;
    repeat (3) @(posedge pclk);
    q.delete();
    step(0, 2'h0);
    exc(24'h00_0032, 2);
    `CHK(av, VEC_INT_BASE + 6'h05);
    @(posedge pclk);
    int_req <= '0;
  endtask
  task automatic t_wdog;
    apb(1, OFS_SYSTEM_CTL, 32'h0000_0000);
    q.delete();
    @(posedge pclk);
    wd <= 1;
    @(posedge pclk);
    wd <= 0;
    #1;
    `CHK(mclr, 1);
    exc(24'h00_0000, 0);
    apb(0, OFS_SYSTEM_CTL, 32'h0000_0000);
    `CHK(r, SYSTEM_CTL_RESET);
    apb(0, 8'h10, 32'h0000_0000);
    `CHK(e, 1);
    `CHK(r, 32'h0000_0000);
  endtask
  initial begin
    rst(6);
    t_nmi();
    t_trap(0);
    apb(1, OFS_SYSTEM_CTL, 32'h0000_0000);
    t_trap(1);
    t_normal();
    t_wdog();
    end_of_test();
  end
endmodule
`default_nettype wire
